/* rtl/dte_timer.sv */
/*
 * Dual 8-bit timer/event counter with APB register access, compare
 * match interrupts and optional 16-bit cascade.
 * Assumes a zero-wait APB master on SYS_CLK, asynchronous event pins
 * and an oscillator-mode level driven from logic on SYS_CLK.
 */
`timescale 1ns/1ps

// Behaviour
// - Two 8-bit up-counters, one step per tick
// - Counter equals compare value raises match request
// - Compare value plus one sets the repeated interval length in ticks
// - Compare registers written as single byte only
// - Compare accepts 00-FF, cascaded 0000-FFFF
// - Compare registers undefined after reset
// - Byte reads per counter, word read cascaded
// - Reset clears both counters to zero
// - Clock select byte register, resets to zero
// - Low nibble codes: edges, fxx taps, prohibited
// - High nibble mirrors low for second counter
// - fxx is fx or fx/2 per mode
// - Match clears counter and counting continues
// - Mode register runs, stops, selects cascade
module dte_timer
    import dte_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    output logic [DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EVENT_IN_ONE,
    input wire logic EVENT_IN_TWO,
    input wire logic OSC_MODE_SEL,
    output logic MATCH_REQUEST_ONE,
    output logic MATCH_REQUEST_TWO,
    output logic IRQ
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Register index to byte address compare
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
        return addr == {idx, 2'b00};
    endfunction

    // Interval step: returns {match, next count}
    function automatic logic [CNT_W:0] step(input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] cmp, input logic run, input logic tick);
        if (!run)
        begin
            return {1'b0, CNT_RST};
        end
        if (tick && cnt == cmp)
        begin
            return {1'b1, CNT_RST};
        end
        if (tick)
        begin
            return {1'b0, cnt + CNT_W'(1)};
        end
        return {1'b0, cnt};
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] clock_select_q;
    logic [CNT_W-1:0] match_value_one_q;
    logic [CNT_W-1:0] match_value_two_q;
    logic [CNT_W-1:0] count_value_one_q;
    logic [CNT_W-1:0] count_value_one_d;
    logic [CNT_W-1:0] count_value_two_q;
    logic [CNT_W-1:0] count_value_two_d;
    logic [2:0] timer_mode_control_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic [1:0] hit_d;
    logic [1:0] req_q;
    logic [DIV_W-1:0] div_q;
    logic [1:0] ev_s1_q;
    logic [1:0] ev_s2_q;
    logic [1:0] ev_s3_q;
    logic [1:0] ev_rise;
    logic [1:0] ev_fall;
    logic tick_one;
    logic tick_two;
    logic [DATA_W-1:0] prdata_q;
    logic wr_acc;
    logic rd_setup;
    logic mapped;
    logic run_one;
    logic run_two;
    logic cascade;
    logic [CNT_W:0] step_one;
    logic [CNT_W:0] step_two;
    logic [2*CNT_W-1:0] wide_count;
    logic [2*CNT_W-1:0] wide_match;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------

    // Zero-wait slave; error on unmapped addresses
    assign PREADY = 1'b1;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign mapped = hit(PADDR, IDX_CLOCK_SELECT) || hit(PADDR, IDX_MATCH_ONE)
        || hit(PADDR, IDX_MATCH_TWO) || hit(PADDR, IDX_COUNT_ONE)
        || hit(PADDR, IDX_COUNT_TWO) || hit(PADDR, IDX_COUNT_WIDE)
        || hit(PADDR, IDX_MODE) || hit(PADDR, IDX_STATUS) || hit(PADDR, IDX_MASK);
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA = prdata_q;

    assign run_one = timer_mode_control_q[MODE_RUN_ONE];
    assign run_two = timer_mode_control_q[MODE_RUN_TWO];
    assign cascade = timer_mode_control_q[MODE_CASCADE];
    assign wide_count = {count_value_two_q, count_value_one_q};
    assign wide_match = {match_value_two_q, match_value_one_q};

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------

    // Clock select, whole-byte write only
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            clock_select_q <= CLKSEL_RST;
        end
        else if (wr_acc && hit(PADDR, IDX_CLOCK_SELECT))
        begin
            clock_select_q <= PWDATA[7:0];
        end
    end

    // Compare registers: no reset, byte-wide fields
    always_ff @(posedge SYS_CLK)
    begin
        if (wr_acc && hit(PADDR, IDX_MATCH_ONE))
        begin
            match_value_one_q <= PWDATA[CNT_W-1:0];
        end
        if (wr_acc && hit(PADDR, IDX_MATCH_TWO))
        begin
            match_value_two_q <= PWDATA[CNT_W-1:0];
        end
    end

    // Run bits and cascade select
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            timer_mode_control_q <= MODE_RST;
        end
        else if (wr_acc && hit(PADDR, IDX_MODE))
        begin
            timer_mode_control_q <= PWDATA[2:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            mask_q <= FLAGS_RST;
        end
        else if (wr_acc && hit(PADDR, IDX_MASK))
        begin
            mask_q <= PWDATA[1:0];
        end
    end

    // Sticky status; a new match wins over write-one-to-clear
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            status_q <= FLAGS_RST;
        end
        else
        begin
            if (wr_acc && hit(PADDR, IDX_STATUS))
            begin
                status_q <= (status_q & ~PWDATA[1:0]) | hit_d;
            end
            else
            begin
                status_q <= status_q | hit_d;
            end
        end
    end

    assign IRQ = |(status_q & mask_q);

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // Read data captured in setup, valid through the access phase
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            prdata_q <= '0;
        end
        else if (rd_setup)
        begin
            prdata_q <= '0;
            if (hit(PADDR, IDX_CLOCK_SELECT))
            begin
                prdata_q[7:0] <= clock_select_q;
            end
            else if (hit(PADDR, IDX_MATCH_ONE))
            begin
                prdata_q[CNT_W-1:0] <= match_value_one_q;
            end
            else if (hit(PADDR, IDX_MATCH_TWO))
            begin
                prdata_q[CNT_W-1:0] <= match_value_two_q;
            end
            else if (hit(PADDR, IDX_COUNT_ONE))
            begin
                prdata_q[CNT_W-1:0] <= count_value_one_q;
            end
            else if (hit(PADDR, IDX_COUNT_TWO))
            begin
                prdata_q[CNT_W-1:0] <= count_value_two_q;
            end
            else if (hit(PADDR, IDX_COUNT_WIDE))
            begin
                prdata_q[2*CNT_W-1:0] <= wide_count;
            end
            else if (hit(PADDR, IDX_MODE))
            begin
                prdata_q[2:0] <= timer_mode_control_q;
            end
            else if (hit(PADDR, IDX_STATUS))
            begin
                prdata_q[1:0] <= status_q;
            end
            else if (hit(PADDR, IDX_MASK))
            begin
                prdata_q[1:0] <= mask_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Count clocks
    // ------------------------------------------------------------

    // Free-running prescaler from the system clock
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            div_q <= '0;
        end
        else
        begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    // Event pins: two-flop sync, third stage for edges
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ev_s1_q <= '0;
            ev_s2_q <= '0;
            ev_s3_q <= '0;
        end
        else
        begin
            ev_s1_q <= {EVENT_IN_TWO, EVENT_IN_ONE};
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
        end
    end

    assign ev_rise = ev_s2_q & ~ev_s3_q;
    assign ev_fall = ~ev_s2_q & ev_s3_q;

    // Low nibble drives counter one
    dte_tick_sel u_sel_one (
        .CODE(clock_select_q[3:0]),
        .OSC_MODE_SEL(OSC_MODE_SEL),
        .DIV_COUNT(div_q),
        .EVENT_RISE(ev_rise[0]),
        .EVENT_FALL(ev_fall[0]),
        .TICK(tick_one)
    );

    // High nibble mirrors the encoding for counter two
    dte_tick_sel u_sel_two (
        .CODE(clock_select_q[7:4]),
        .OSC_MODE_SEL(OSC_MODE_SEL),
        .DIV_COUNT(div_q),
        .EVENT_RISE(ev_rise[1]),
        .EVENT_FALL(ev_fall[1]),
        .TICK(tick_two)
    );

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------

    assign step_one = step(count_value_one_q, match_value_one_q, run_one, tick_one);
    assign step_two = step(count_value_two_q, match_value_two_q, run_two, tick_two);

    // Next counts: two 8-bit channels or one 16-bit cascade
    always_comb
    begin
        count_value_one_d = step_one[CNT_W-1:0];
        count_value_two_d = step_two[CNT_W-1:0];
        hit_d = {step_two[CNT_W], step_one[CNT_W]};
        if (cascade)
        begin
            hit_d = 2'b00;
            count_value_one_d = count_value_one_q;
            count_value_two_d = count_value_two_q;
            if (!run_one)
            begin
                count_value_one_d = CNT_RST;
                count_value_two_d = CNT_RST;
            end
            else if (tick_one && wide_count == wide_match)
            begin
                count_value_one_d = CNT_RST;
                count_value_two_d = CNT_RST;
                hit_d[ST_MATCH_ONE] = 1'b1;
            end
            else if (tick_one)
            begin
                {count_value_two_d, count_value_one_d} = wide_count + 16'h0001;
            end
        end
    end

    // Counter state, cleared by reset
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            count_value_one_q <= CNT_RST;
            count_value_two_q <= CNT_RST;
        end
        else
        begin
            count_value_one_q <= count_value_one_d;
            count_value_two_q <= count_value_two_d;
        end
    end

    // Match request pulses, one cycle each
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            req_q <= 2'b00;
        end
        else
        begin
            req_q <= hit_d;
        end
    end

    assign MATCH_REQUEST_ONE = req_q[ST_MATCH_ONE];
    assign MATCH_REQUEST_TWO = req_q[ST_MATCH_TWO];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_match_one;
        !cascade && run_one && tick_one && count_value_one_q == match_value_one_q;
    endsequence

    sequence s_cleared_req;
        count_value_one_q == CNT_RST && MATCH_REQUEST_ONE;
    endsequence

    a_match_clear_one:
        assert property (s_match_one |=> s_cleared_req ##1 !MATCH_REQUEST_ONE)
        else $error("counter one not cleared on match");

    a_match_req_two:
        assert property (!cascade && run_two && tick_two
            && count_value_two_q == match_value_two_q |=> MATCH_REQUEST_TWO)
        else $error("match request two missing");

    a_count_step:
        assert property (!cascade && run_one && tick_one
            && count_value_one_q != match_value_one_q
            |=> count_value_one_q == $past(count_value_one_q) + 8'h01)
        else $error("counter one did not advance by one");

    a_hold_no_tick:
        assert property (!cascade && !tick_one |=> $stable(count_value_one_q)
            || count_value_one_q == CNT_RST)
        else $error("counter one moved without a tick");

    a_stop_clears:
        assert property (!run_two && !cascade |=> count_value_two_q == CNT_RST)
        else $error("stopped counter two not zero");

    a_cascade_carry:
        assert property (cascade && run_one && tick_one && count_value_one_q == 8'hFF
            && wide_count != wide_match
            |=> count_value_two_q == $past(count_value_two_q) + 8'h01
            && count_value_one_q == CNT_RST)
        else $error("cascade carry lost");

    a_clksel_write:
        assert property (wr_acc && hit(PADDR, IDX_CLOCK_SELECT)
            |=> clock_select_q == $past(PWDATA[7:0]))
        else $error("clock select write lost");

    a_wide_read:
        assert property (rd_setup && hit(PADDR, IDX_COUNT_WIDE)
            |=> PRDATA == {16'h0000, $past(wide_count)})
        else $error("wide count read mismatch");

    a_tap_fast:
        assert property (clock_select_q[3:0] == CODE_DIV_FIRST && !OSC_MODE_SEL
            && tick_one |=> !tick_one [*3])
        else $error("fxx/2 tick too fast");

    a_prohibited_code:
        assert property (clock_select_q[3:0] inside {4'h2, 4'h3, 4'h4, 4'h5} |-> !tick_one)
        else $error("prohibited code produced a tick");

    a_irq_level:
        assert property (status_q[ST_MATCH_ONE] && mask_q[ST_MATCH_ONE] |-> IRQ)
        else $error("masked-in status without interrupt");

    a_status_sticky:
        assert property (MATCH_REQUEST_ONE |-> status_q[ST_MATCH_ONE])
        else $error("match flag not set");

endmodule

/* rtl/dte_pkg.sv */
/*
 * Shared constants for the dual 8-bit timer/event counter: register
 * indices, field positions, reset values and clock-select codes.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package dte_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int CNT_W = 8;
    localparam int DIV_W = 13;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_CLOCK_SELECT = 16'hFF41;
    localparam logic [15:0] IDX_MATCH_ONE = 16'hFF42;
    localparam logic [15:0] IDX_MATCH_TWO = 16'hFF43;
    localparam logic [15:0] IDX_COUNT_ONE = 16'hFF44;
    localparam logic [15:0] IDX_COUNT_TWO = 16'hFF45;
    localparam logic [15:0] IDX_COUNT_WIDE = 16'hFF46;
    localparam logic [15:0] IDX_MODE = 16'hFF47;
    localparam logic [15:0] IDX_STATUS = 16'hFF48;
    localparam logic [15:0] IDX_MASK = 16'hFF49;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] CLKSEL_RST = 8'h00;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [1:0] FLAGS_RST = 2'h0;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam int MODE_RUN_ONE = 0;
    localparam int MODE_RUN_TWO = 1;
    localparam int MODE_CASCADE = 2;
    localparam int ST_MATCH_ONE = 0;
    localparam int ST_MATCH_TWO = 1;

    // ------------------------------------------------------------
    // Clock-select codes
    // ------------------------------------------------------------
    localparam logic [3:0] CODE_FALL = 4'h0;
    localparam logic [3:0] CODE_RISE = 4'h1;
    localparam logic [3:0] CODE_DIV_FIRST = 4'h6;
    localparam logic [3:0] CODE_DIV_LAST = 4'hE;
    localparam logic [3:0] CODE_DIV_TOP = 4'hF;
    localparam logic [3:0] SHIFT_BASE_OFS = 4'h5;
    localparam logic [3:0] SHIFT_TOP = 4'hB;

endpackage

/* rtl/dte_tick_sel.sv */
/*
 * Count-clock selector for one channel: picks an event edge or a
 * power-of-two tap of the shared prescaler and yields a one-cycle tick.
 * Assumes the prescaler counter advances every system clock and the
 * event edges are already synchronised single-cycle pulses.
 */
`timescale 1ns/1ps
module dte_tick_sel
    import dte_pkg::*;
(
    input wire logic [3:0] CODE,
    input wire logic OSC_MODE_SEL,
    input wire logic [DIV_W-1:0] DIV_COUNT,
    input wire logic EVENT_RISE,
    input wire logic EVENT_FALL,
    output logic TICK
);

    // ------------------------------------------------------------
    // Division exponent for the fxx taps
    // ------------------------------------------------------------
    function automatic logic [3:0] div_shift(input logic [3:0] code);
        if (code == CODE_DIV_TOP)
        begin
            return SHIFT_TOP;
        end
        return code - SHIFT_BASE_OFS;
    endfunction

    logic [3:0] shift;
    logic [DIV_W-1:0] tap_mask;

    // fxx is fx when the mode bit is 1, fx/2 otherwise
    assign shift = div_shift(CODE) + {3'h0, ~OSC_MODE_SEL};
    assign tap_mask = (DIV_W'(1) << shift) - DIV_W'(1);

    // Code decode; prohibited codes never tick
    always_comb
    begin
        TICK = 1'b0;
        if (CODE == CODE_FALL)
        begin
            TICK = EVENT_FALL;
        end
        else if (CODE == CODE_RISE)
        begin
            TICK = EVENT_RISE;
        end
        else if ((CODE >= CODE_DIV_FIRST && CODE <= CODE_DIV_LAST) || CODE == CODE_DIV_TOP)
        begin
            TICK = (DIV_COUNT & tap_mask) == tap_mask;
        end
    end

endmodule

/* tb/tb_dte_timer.sv */
/*
 * Self-checking bench for the dual 8-bit timer: registers over APB,
 * interval periods, clock codes, event counting, cascade and interrupt.
 * Assumes the design answers APB with PREADY and pulses match outputs.
 */
`timescale 1ns/1ps
module tb_dte_timer
    import dte_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    logic sys_clk, resetn, psel, penable, pwrite, ev1, ev2, osc;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic pready, pslverr, mr1, mr2, irq, err;
    int n_mismatch, samples_checked, n_two, per;

    dte_timer i_dut (.SYS_CLK(sys_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EVENT_IN_ONE(ev1), .EVENT_IN_TWO(ev2), .OSC_MODE_SEL(osc),
        .MATCH_REQUEST_ONE(mr1), .MATCH_REQUEST_TWO(mr2), .IRQ(irq));

    // Clock generator
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Count second-channel match pulses
    always @(posedge sys_clk)
        if (mr2 === 1'b1) n_two++;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task bad(input string what);
        n_mismatch++;
        $display("MISMATCH %s expected answer seen timeout", what);
        summarize();
    endtask

    // One APB transfer, held until PREADY is sampled high
    task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) bad("apb ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(what, rd, exp);
    endtask

    // Cycles until the next match pulse of one channel
    task wait_pulse(input logic two, input int bound, output int n);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while ((two ? mr2 : mr1) !== 1'b1 && n < bound);
        if ((two ? mr2 : mr1) !== 1'b1) bad("match pulse");
    endtask

    task measure(input logic two, input int exp, input string what);
        wait_pulse(two, 10000, per);
        wait_pulse(two, exp + 10, per);
        chk(what, per, exp);
    endtask

    task set_osc(input logic v);
        @(posedge sys_clk);
        osc <= v;
    endtask

    task pulses(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            ev1 <= 1'b1;
            ev2 <= 1'b1;
            repeat (3) @(posedge sys_clk);
            ev1 <= 1'b0;
            ev2 <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
        repeat (6) @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset_state;
        rdchk("clock select", IDX_CLOCK_SELECT, 32'h0);
        rdchk("count one", IDX_COUNT_ONE, 32'h0);
        rdchk("count two", IDX_COUNT_TWO, 32'h0);
        rdchk("mode", IDX_MODE, 32'h0);
        chk("irq", irq, 32'h0);
    endtask

    task t_regs;
        wr(IDX_CLOCK_SELECT, 32'hA5);
        rdchk("clock select", IDX_CLOCK_SELECT, 32'hA5);
        wr(IDX_CLOCK_SELECT, 32'h0);
        wr(IDX_MATCH_ONE, 32'hFF);
        rdchk("match one", IDX_MATCH_ONE, 32'hFF);
        wr(IDX_MATCH_TWO, 32'h00);
        rdchk("match two", IDX_MATCH_TWO, 32'h00);
        chk("mapped error", err, 32'h0);
        wr(IDX_COUNT_ONE, 32'h33);
        rdchk("count read only", IDX_COUNT_ONE, 32'h0);
        apb(1'b0, 16'hFF60, 32'h0);
        chk("unmapped error", err, 32'h1);
        chk("unmapped data", rd, 32'h0);
    endtask

    task t_interval;
        logic [7:0] m[3];
        m = '{8'h00, 8'h02, 8'hFF};
        set_osc(1'b1);
        wr(IDX_CLOCK_SELECT, 32'h06);
        foreach (m[i])
        begin
            wr(IDX_MODE, 32'h0);
            wr(IDX_MATCH_ONE, {24'h0, m[i]});
            wr(IDX_MODE, 32'h1);
            measure(1'b0, (m[i] + 1) * 2, "interval one");
        end
        wr(IDX_MODE, 32'h0);
        rdchk("status", IDX_STATUS, 32'h1);
        #1 chk("irq masked", irq, 32'h0);
        wr(IDX_MASK, 32'h1);
        #1 chk("irq unmasked", irq, 32'h1);
        wr(IDX_STATUS, 32'h1);
        #1 chk("irq cleared", irq, 32'h0);
        rdchk("status cleared", IDX_STATUS, 32'h0);
        wr(IDX_MASK, 32'h0);
    endtask

    task t_codes;
        int s, n;
        wr(IDX_MATCH_TWO, 32'h0);
        for (int fast = 1; fast >= 0; fast--)
        begin
            set_osc(fast[0]);
            for (int c = 6; c <= 15; c++)
            begin
                wr(IDX_MODE, 32'h0);
                wr(IDX_CLOCK_SELECT, (c << 4) | c);
                wr(IDX_MODE, 32'h2);
                s = (c == 15 ? 11 : c - 5) + (fast == 1 ? 0 : 1);
                measure(1'b1, 1 << s, "tap period");
            end
        end
        wr(IDX_MODE, 32'h0);
        wr(IDX_CLOCK_SELECT, 32'h20);
        n = n_two;
        wr(IDX_MODE, 32'h2);
        repeat (100) @(posedge sys_clk);
        rdchk("prohibited count", IDX_COUNT_TWO, 32'h0);
        chk("prohibited pulses", n_two, n);
        wr(IDX_MODE, 32'h0);
    endtask

    task t_events;
        wr(IDX_MATCH_ONE, 32'hFF);
        wr(IDX_MATCH_TWO, 32'hFF);
        wr(IDX_CLOCK_SELECT, 32'h00);
        wr(IDX_MODE, 32'h3);
        pulses(3);
        rdchk("fall count one", IDX_COUNT_ONE, 32'h3);
        rdchk("fall count two", IDX_COUNT_TWO, 32'h3);
        wr(IDX_MODE, 32'h0);
        wr(IDX_CLOCK_SELECT, 32'h11);
        wr(IDX_MODE, 32'h3);
        pulses(5);
        rdchk("rise count one", IDX_COUNT_ONE, 32'h5);
        rdchk("rise count two", IDX_COUNT_TWO, 32'h5);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset_state();
    endtask

    task t_cascade;
        int n;
        wr(IDX_CLOCK_SELECT, 32'h01);
        wr(IDX_MATCH_ONE, 32'hFF);
        wr(IDX_MATCH_TWO, 32'hFF);
        wr(IDX_MODE, 32'h5);
        pulses(258);
        rdchk("wide count", IDX_COUNT_WIDE, 32'h0102);
        rdchk("low byte", IDX_COUNT_ONE, 32'h02);
        rdchk("high byte", IDX_COUNT_TWO, 32'h01);
        wr(IDX_MODE, 32'h0);
        set_osc(1'b1);
        wr(IDX_CLOCK_SELECT, 32'h06);
        wr(IDX_MATCH_ONE, 32'h02);
        wr(IDX_MATCH_TWO, 32'h01);
        n = n_two;
        wr(IDX_MODE, 32'h5);
        measure(1'b0, 518, "cascade interval");
        chk("cascade second pulses", n_two, n);
        wr(IDX_MODE, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        ev1 = 1'b0;
        ev2 = 1'b0;
        osc = 1'b1;
        n_mismatch = 0;
        samples_checked = 0;
        n_two = 0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset_state();
        t_regs();
        t_interval();
        t_codes();
        t_events();
        t_cascade();
        summarize();
    end
endmodule
